//--- shared/pmg_pkg.sv
// pmg_pkg: constants and types of the power mode and
// peripheral clock gating block.
// assumes: a 32-bit APB bus and one always-on system clock.
package pmg_pkg;

  // ==========================================
  // register map
  localparam logic [31:0] PMG_MODE_ADDR = 32'hE01FC0C0;
  localparam logic [31:0] PMG_PCE_ADDR = 32'hE01FC0C4;

  // ==========================================
  // mode register fields
  localparam int PMG_HALT_CPU_CLOCK_BIT = 0;
  localparam int PMG_DEEP_SLEEP_BIT = 1;
  localparam logic [7:0] PMG_MODE_RST = 8'h00;

  // ==========================================
  // peripheral clock enable fields
  localparam int PMG_TIMER_A = 1;
  localparam int PMG_TIMER_B = 2;
  localparam int PMG_SERIAL_PORT_A = 3;
  localparam int PMG_SERIAL_PORT_B = 4;
  localparam int PMG_PULSE_WIDTH_UNIT = 5;
  localparam int PMG_TWO_WIRE_BUS = 7;
  localparam int PMG_SERIAL_PERIPH_A = 8;
  localparam int PMG_CALENDAR_CLOCK = 9;
  localparam int PMG_SERIAL_PERIPH_B = 10;
  localparam int PMG_EXT_MEMORY_CTRL = 11;
  localparam int PMG_ANALOG_CONVERTER = 12;
  localparam int PMG_CAN_CTRL_1 = 13;
  localparam int PMG_CAN_CTRL_2 = 14;
  localparam int PMG_CAN_CTRL_3 = 15;
  localparam int PMG_CAN_CTRL_4 = 16;
  // reset value equals the writable mask in both variants
  localparam logic [31:0] PMG_PCE_RST_SMALL = 32'h00007FBE;
  localparam logic [31:0] PMG_PCE_RST_LARGE = 32'h0001FFBE;

  // ==========================================
  // carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } pmg_apb_req_type;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } pmg_apb_rsp_type;

  typedef struct packed {
    logic cpu;
    logic osc;
    logic always_on;
    logic acc_filter;
    logic [31:0] periph;
  } pmg_clk_en_type;

  typedef enum logic [1:0] {
    PMG_RUN,
    PMG_SLEEP,
    PMG_DEEP,
    PMG_RESTART
  } pmg_fsm_type;

  typedef struct packed {
    pmg_fsm_type fsm;
    logic halt_cpu_clock_bit;
    logic deep_sleep_bit;
    logic [31:0] pce;
    pmg_apb_rsp_type rsp;
    pmg_clk_en_type clk;
  } pmg_state_type;

endpackage

//--- src/pmg_power_ctrl.sv
// pmg_power_ctrl: power mode register, peripheral clock
// enable register and the clock enables they drive.
// assumes: CORE_CLK_I never stops; enables feed latch-based
// clock gate cells outside; wake inputs are synchronous.
`timescale 1ns/1ps

module pmg_power_ctrl
  import pmg_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic CORE_CLK_I, // system clock
  input wire logic RSTN_I, // async reset, active low
  input wire pmg_apb_req_type APB_REQ_I, // apb request
  output pmg_apb_rsp_type APB_RSP_O, // apb answer
  input wire logic IRQ_WAKE_I, // enabled interrupt pending
  input wire logic EXT_WAKE_I, // external interrupt wakeup
  input wire logic OSC_READY_I, // oscillator running again
  output pmg_clk_en_type CLK_EN_O // clock gate enables
);

  // ==========================================
  // constants by variant
  localparam logic [31:0] PCE_RST =
    LARGE_VARIANT ? PMG_PCE_RST_LARGE : PMG_PCE_RST_SMALL;
  localparam logic [31:0] PCE_MASK = PCE_RST;

  pmg_state_type st_r;
  pmg_state_type st_nxt;
  logic access_done;
  logic hit_mode;
  logic hit_pce;

  // clocks reach peripherals only while the oscillator runs
  function automatic logic clocks_run(input pmg_fsm_type f);
    clocks_run = (f == PMG_RUN) || (f == PMG_SLEEP);
  endfunction

  // ==========================================
  // next state
  always_comb begin
    st_nxt = st_r;
    hit_mode = APB_REQ_I.paddr == PMG_MODE_ADDR;
    hit_pce = APB_REQ_I.paddr == PMG_PCE_ADDR;
    // one wait state, so every answer is from a flop
    access_done = APB_REQ_I.psel && APB_REQ_I.penable && st_r.rsp.pready;
    st_nxt.rsp.pready = APB_REQ_I.psel && APB_REQ_I.penable && !st_r.rsp.pready;
    st_nxt.rsp.pslverr = 1'b0;
    st_nxt.rsp.prdata = 32'h00000000;
    if (st_nxt.rsp.pready) begin
      st_nxt.rsp.pslverr = !(hit_mode || hit_pce);
      if (hit_mode) begin
        st_nxt.rsp.prdata[PMG_HALT_CPU_CLOCK_BIT] = st_r.halt_cpu_clock_bit;
        st_nxt.rsp.prdata[PMG_DEEP_SLEEP_BIT] = st_r.deep_sleep_bit;
      end else if (hit_pce) begin
        st_nxt.rsp.prdata = st_r.pce;
      end
    end
    // write takes effect at the completing edge only
    if (access_done && APB_REQ_I.pwrite) begin
      if (hit_mode) begin
        // bits 7:2 are dropped; software keeps them zero
        st_nxt.halt_cpu_clock_bit = APB_REQ_I.pwdata[PMG_HALT_CPU_CLOCK_BIT];
        st_nxt.deep_sleep_bit = APB_REQ_I.pwdata[PMG_DEEP_SLEEP_BIT];
      end else if (hit_pce) begin
        st_nxt.pce = APB_REQ_I.pwdata & PCE_MASK;
      end
    end

    // mode entry waits a cycle after the bus write completes,
    // so the writing instruction has retired before the stop
    unique case (st_r.fsm)
      PMG_RUN: begin
        if (st_r.deep_sleep_bit) begin
          st_nxt.fsm = PMG_DEEP;
        end else if (st_r.halt_cpu_clock_bit) begin
          st_nxt.fsm = PMG_SLEEP;
        end
      end
      PMG_SLEEP: begin
        if (IRQ_WAKE_I || EXT_WAKE_I) begin
          st_nxt.halt_cpu_clock_bit = 1'b0;
          st_nxt.fsm = PMG_RUN;
        end
      end
      PMG_DEEP: begin
        if (EXT_WAKE_I) begin
          st_nxt.fsm = PMG_RESTART;
        end
      end
      PMG_RESTART: begin
        // clocks stay off until the oscillator is stable
        if (OSC_READY_I) begin
          st_nxt.deep_sleep_bit = 1'b0;
          st_nxt.halt_cpu_clock_bit = 1'b0;
          st_nxt.fsm = PMG_RUN;
        end
      end
    endcase

    // enables change only at a core edge; the gate cell
    // latches them, so the gated clocks never glitch
    st_nxt.clk.osc = st_nxt.fsm != PMG_DEEP;
    st_nxt.clk.cpu = st_nxt.fsm == PMG_RUN;
    st_nxt.clk.always_on = clocks_run(st_nxt.fsm);
    st_nxt.clk.periph = clocks_run(st_nxt.fsm) ? st_nxt.pce : 32'h00000000;
    st_nxt.clk.acc_filter = clocks_run(st_nxt.fsm) &&
      (st_nxt.pce[PMG_CAN_CTRL_1] || st_nxt.pce[PMG_CAN_CTRL_2]);
  end

  // ==========================================
  // state register
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      st_r.fsm <= PMG_RUN;
      st_r.halt_cpu_clock_bit <= PMG_MODE_RST[PMG_HALT_CPU_CLOCK_BIT];
      st_r.deep_sleep_bit <= PMG_MODE_RST[PMG_DEEP_SLEEP_BIT];
      st_r.pce <= PCE_RST;
      st_r.rsp <= '0;
      st_r.clk.cpu <= 1'b1;
      st_r.clk.osc <= 1'b1;
      st_r.clk.always_on <= 1'b1;
      st_r.clk.acc_filter <= 1'b1;
      st_r.clk.periph <= PCE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign APB_RSP_O = st_r.rsp;
  assign CLK_EN_O = st_r.clk;

  // ==========================================
  // assertions
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);

  property p_idle_cpu_off;
    st_r.fsm == PMG_SLEEP |-> !CLK_EN_O.cpu && CLK_EN_O.periph == st_r.pce;
  endproperty
  a_idle_cpu_off: assert property (p_idle_cpu_off) else $error("idle clocks wrong");

  property p_idle_wake;
    st_r.fsm == PMG_SLEEP && (IRQ_WAKE_I || EXT_WAKE_I) |=>
      CLK_EN_O.cpu && !st_r.halt_cpu_clock_bit;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle wake failed");

  property p_deep_off;
    st_r.fsm == PMG_DEEP |->
      !CLK_EN_O.osc && !CLK_EN_O.cpu && !CLK_EN_O.always_on && CLK_EN_O.periph == 32'h00000000;
  endproperty
  a_deep_off: assert property (p_deep_off) else $error("clock on in power-down");

  // the oscillator needs several cycles, so check the restart state itself
  property p_deep_wake;
    st_r.fsm == PMG_RESTART && OSC_READY_I |=>
      !st_r.deep_sleep_bit && CLK_EN_O.cpu && CLK_EN_O.osc;
  endproperty
  a_deep_wake: assert property (p_deep_wake) else $error("power-down wake failed");

  property p_always_on;
    st_r.fsm == PMG_RUN |-> CLK_EN_O.always_on && CLK_EN_O.cpu;
  endproperty
  a_always_on: assert property (p_always_on) else $error("always-on clock off");

  property p_gate;
    clocks_run(st_r.fsm) |-> CLK_EN_O.periph == st_r.pce;
  endproperty
  a_gate: assert property (p_gate) else $error("gate differs from enable");

  property p_reserved;
    (st_r.pce & ~PCE_MASK) == 32'h00000000 && !st_r.pce[0] && !st_r.pce[6];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_reset_val;
    $rose(RSTN_I) |-> st_r.pce == PCE_RST && !st_r.halt_cpu_clock_bit && !st_r.deep_sleep_bit;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("reset value wrong");

  property p_filter;
    CLK_EN_O.acc_filter == (clocks_run(st_r.fsm) &&
      (st_r.pce[PMG_CAN_CTRL_1] || st_r.pce[PMG_CAN_CTRL_2]));
  endproperty
  a_filter: assert property (p_filter) else $error("filter enable wrong");

  property p_deep_wins;
    st_r.fsm == PMG_RUN && access_done && APB_REQ_I.pwrite && hit_mode &&
      APB_REQ_I.pwdata[PMG_DEEP_SLEEP_BIT] && APB_REQ_I.pwdata[PMG_HALT_CPU_CLOCK_BIT]
      |=> ##1 st_r.fsm == PMG_DEEP;
  endproperty
  a_deep_wins: assert property (p_deep_wins) else $error("idle beat power-down");

  property p_wake_once;
    st_r.fsm == PMG_SLEEP && IRQ_WAKE_I |=> st_r.fsm == PMG_RUN ##1 st_r.fsm == PMG_RUN;
  endproperty
  a_wake_once: assert property (p_wake_once) else $error("wake re-entered idle");

  property p_read;
    APB_RSP_O.pready && APB_REQ_I.psel && hit_pce && !APB_REQ_I.pwrite |->
      APB_RSP_O.prdata == st_r.pce;
  endproperty
  a_read: assert property (p_read) else $error("read data wrong");

  property p_write;
    access_done && APB_REQ_I.pwrite && hit_pce |=>
      st_r.pce == ($past(APB_REQ_I.pwdata) & PCE_MASK);
  endproperty
  a_write: assert property (p_write) else $error("write lost");

  property p_deep_restart;
    st_r.fsm == PMG_DEEP && EXT_WAKE_I |=> st_r.fsm == PMG_RESTART && CLK_EN_O.osc;
  endproperty
  a_deep_restart: assert property (p_deep_restart) else $error("oscillator not restarted");

  // an ordinary interrupt must not wake power-down
  property p_deep_irq_ignored;
    st_r.fsm == PMG_DEEP && !EXT_WAKE_I |=> st_r.fsm == PMG_DEEP && !CLK_EN_O.osc;
  endproperty
  a_deep_irq_ignored: assert property (p_deep_irq_ignored) else $error("power-down left early");

  property p_restart_hold;
    st_r.fsm == PMG_RESTART && !OSC_READY_I |=> st_r.fsm == PMG_RESTART && CLK_EN_O.osc &&
      !CLK_EN_O.cpu && CLK_EN_O.periph == 32'h00000000;
  endproperty
  a_restart_hold: assert property (p_restart_hold) else $error("clock before oscillator ready");

  property p_idle_entry;
    st_r.fsm == PMG_RUN && st_r.halt_cpu_clock_bit && !st_r.deep_sleep_bit |=>
      st_r.fsm == PMG_SLEEP && !CLK_EN_O.cpu && CLK_EN_O.osc;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");

  property p_rsp_quiet;
    !APB_RSP_O.pready |-> APB_RSP_O.prdata == 32'h00000000 && !APB_RSP_O.pslverr;
  endproperty
  a_rsp_quiet: assert property (p_rsp_quiet) else $error("answer outside ready");

  property p_pready_pulse;
    APB_RSP_O.pready |=> !APB_RSP_O.pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("ready longer than a cycle");

  c_sleep_wake: cover property (st_r.fsm == PMG_SLEEP ##1 st_r.fsm == PMG_RUN);
  c_deep_wake: cover property (st_r.fsm == PMG_RESTART ##1 st_r.fsm == PMG_RUN);
  c_pce_write: cover property (access_done && APB_REQ_I.pwrite && hit_pce);
  c_bad_addr: cover property (APB_RSP_O.pready && APB_RSP_O.pslverr);
  c_idle_ext: cover property (st_r.fsm == PMG_SLEEP && EXT_WAKE_I);

endmodule // pmg_power_ctrl

//--- test/pmg_osc_model.sv
// pmg_osc_model: oscillator seen from the power block.
// assumes: ready drops at the first clock edge that sees the enable low and
// returns a fixed number of cycles after it rises again.
`timescale 1ns/1ps

module pmg_osc_model #(
  parameter int DLY = 5
) (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic osc_en_i, // oscillator enable
  output logic osc_ready_o // oscillator stable
);
  int cnt;

  // ==========================================
  // start-up delay
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 0;
      osc_ready_o <= 1'b1;
    end else if (!osc_en_i) begin
      cnt <= 0;
      osc_ready_o <= 1'b0;
    end else if (cnt == DLY) begin
      osc_ready_o <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // pmg_osc_model

//--- test/pmg_power_ctrl_tb.sv
// pmg_power_ctrl_tb: self-checking bench of the power block.
// assumes: large variant, one wait state apb slave.
`timescale 1ns/1ps

module pmg_power_ctrl_tb
  import pmg_pkg::*;
;
  typedef struct packed {
    logic [31:0] wd;
    logic [31:0] ex;
    logic acc;
  } pmg_row_type;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic irq = 1'b0;
  logic ext = 1'b0;
  logic osc_rdy;
  pmg_apb_req_type req = '0;
  pmg_apb_rsp_type rsp;
  pmg_clk_en_type ce;
  logic [31:0] q;
  logic e;
  int n_errors = 0;
  int num_checks = 0;
  // last row leaves a nonzero value for the power-down restore check
  pmg_row_type rows [5] = '{
    '{32'h0001FFBE, 32'h0001FFBE, 1'b1},
    '{32'h00000000, 32'h00000000, 1'b0},
    '{32'h00000002, 32'h00000002, 1'b0},
    '{32'h00004000, 32'h00004000, 1'b1},
    '{32'h00002000, 32'h00002000, 1'b1}};

  always #12.5 clk = ~clk;

  pmg_power_ctrl #(.LARGE_VARIANT(1'b1)) u_pmg_power_ctrl (
    .CORE_CLK_I(clk), .RSTN_I(rstn), .APB_REQ_I(req), .APB_RSP_O(rsp),
    .IRQ_WAKE_I(irq), .EXT_WAKE_I(ext), .OSC_READY_I(osc_rdy), .CLK_EN_O(ce));

  pmg_osc_model #(.DLY(5)) u_pmg_osc_model (
    .clk_i(clk), .rst_n_i(rstn), .osc_en_i(ce.osc), .osc_ready_o(osc_rdy));

  // ==========================================
  // helpers
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (rsp.pready !== 1'b1 && i < 20);
    chk("pready", 32'd1, {31'd0, rsp.pready});
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask

  task automatic wait_cpu;
    int i;
    for (i = 0; i < 40 && ce.cpu !== 1'b1; i++) begin
      @(posedge clk);
    end
    chk("cpu wake", 32'd1, {31'd0, ce.cpu});
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(25 * 5000);
    n_errors++;
    final_report();
  end

  // ==========================================
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    chk("periph rst", PMG_PCE_RST_LARGE, ce.periph);
    apb(1'b0, PMG_PCE_ADDR, '0);
    chk("pce rst", PMG_PCE_RST_LARGE, q);
    apb(1'b0, PMG_MODE_ADDR, '0);
    chk("mode rst", 32'h0, q);
    foreach (rows[k]) begin
      apb(1'b1, PMG_PCE_ADDR, rows[k].wd);
      apb(1'b0, PMG_PCE_ADDR, '0);
      chk("pce rd", rows[k].ex, q);
      chk("periph", rows[k].ex, ce.periph);
      chk("acc filter", {31'd0, rows[k].acc}, {31'd0, ce.acc_filter});
      chk("always on", 32'd1, {31'd0, ce.always_on});
    end
    // idle: peripherals keep running
    apb(1'b1, PMG_MODE_ADDR, 32'h1);
    repeat (3) @(posedge clk);
    chk("idle cpu", 32'd0, {31'd0, ce.cpu});
    chk("idle periph", 32'h2000, ce.periph);
    chk("idle osc", 32'd1, {31'd0, ce.osc});
    irq <= 1'b1;
    wait_cpu();
    irq <= 1'b0;
    apb(1'b0, PMG_MODE_ADDR, '0);
    chk("mode after idle", 32'h0, q);
    // idle again, left by an external wakeup this time
    apb(1'b1, PMG_MODE_ADDR, 32'h1);
    repeat (3) @(posedge clk);
    chk("idle2 cpu", 32'd0, {31'd0, ce.cpu});
    ext <= 1'b1;
    wait_cpu();
    ext <= 1'b0;
    // both bits: power-down wins, interrupt alone does not wake
    apb(1'b1, PMG_MODE_ADDR, 32'h3);
    repeat (3) @(posedge clk);
    chk("pd osc", 32'd0, {31'd0, ce.osc});
    chk("pd cpu", 32'd0, {31'd0, ce.cpu});
    chk("pd periph", 32'h0, ce.periph);
    chk("pd always on", 32'd0, {31'd0, ce.always_on});
    chk("pd filter", 32'd0, {31'd0, ce.acc_filter});
    irq <= 1'b1;
    repeat (4) @(posedge clk);
    chk("pd irq osc", 32'd0, {31'd0, ce.osc});
    irq <= 1'b0;
    ext <= 1'b1;
    @(posedge clk);
    ext <= 1'b0;
    wait_cpu();
    chk("pd restore", 32'h2000, ce.periph);
    apb(1'b0, PMG_MODE_ADDR, '0);
    chk("mode after pd", 32'h0, q);
    // unmapped address
    apb(1'b0, 32'hE01FC0C8, '0);
    chk("slverr", 32'd1, {31'd0, e});
    chk("unmapped rd", 32'h0, q);
    // reset in mid-run
    apb(1'b1, PMG_PCE_ADDR, 32'h0);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk("periph rerst", PMG_PCE_RST_LARGE, ce.periph);
    chk("cpu rerst", 32'd1, {31'd0, ce.cpu});
    final_report();
  end
endmodule // pmg_power_ctrl_tb
